//--- src/scd_top.sv
// system control coprocessor transfer decode, trap and register file
`timescale 1ns/1ps
// Notes on behaviour
// - registers reached only by privileged transfers
// - other coprocessor-15 forms trap as undefined
// - transfer pattern: class 1110, cp 15, bit4
// - extract cond, opcodes, direction, register fields
// - wrong-direction access result is undefined
// - undefined locations harmless, any read value
// - fetch address below 32 MB relocated by process id
// - protection pass and hit return data
// - pass and miss translate, go external
// - reset clears bits, straps load two
// - register zero: id or cache type
module scd_top #(
   parameter logic [31:0] ID_WORD = scd_pkg::ID_WORD_DEFAULT,
   parameter logic [31:0] CACHE_TYPE = scd_pkg::CACHE_TYPE_DEFAULT
) (
   input wire logic MCLK,
   input wire logic RESET_N,
   input wire logic HIGH_VECTOR_STRAP,
   input wire logic ENDIAN_STRAP,
   input wire logic CP_VALID,
   input wire logic [31:0] CP_INSTR,
   input wire logic CP_COND_PASS,
   input wire logic CP_PRIVILEGED,
   input wire logic [31:0] CP_CORE_DATA,
   output logic CP_DONE,
   output logic CP_UNDEF,
   output logic CP_CORE_WE,
   output logic [3:0] CP_CORE_REG,
   output logic [31:0] CP_CORE_RDATA,
   output logic [3:0] CP_COND,
   output logic [31:0] CTRL_WORD,
   output logic [31:0] TTB_WORD,
   output logic [31:0] DOMAIN_WORD,
   input wire logic FETCH_REQ,
   input wire logic [31:0] FETCH_VA,
   output logic [31:0] FETCH_MVA,
   output logic FETCH_MVA_VALID,
   input wire logic PROT_ABORT,
   input wire logic ICACHE_HIT,
   input wire logic [31:0] ICACHE_DATA,
   input wire logic [31:0] MMU_PA,
   output logic FETCH_DATA_VALID,
   output logic [31:0] FETCH_DATA,
   output logic FETCH_ABORT,
   output logic BUS_REQ,
   output logic [31:0] BUS_ADDR
);
   logic [3:0] cond;
   logic [2:0] opc1;
   logic dir_to_core;
   logic [3:0] primary_creg_field;
   logic [3:0] core_reg;
   logic [3:0] cpnum;
   logic [2:0] opc2;
   logic [3:0] secondary_creg_field;
   logic aimed_here;
   logic is_xfer;
   logic legal;
   logic illegal;
   logic [31:0] read_val;
   logic [31:0] ctrl_r;
   logic [31:0] ttb_r;
   logic [31:0] domain_r;
   logic [6:0] pid_r;
   logic [31:0] context_r;
   logic done_r;
   logic undef_r;
   logic core_we_r;
   logic [3:0] core_reg_r;
   logic [31:0] core_rdata_r;
   logic [3:0] cond_r;

   scd_ctx_if ctx ();

   assign cond = CP_INSTR[scd_pkg::COND_MSB:scd_pkg::COND_LSB];
   assign opc1 = CP_INSTR[scd_pkg::OPC1_MSB:scd_pkg::OPC1_LSB];
   assign dir_to_core = CP_INSTR[scd_pkg::DIR_BIT];
   assign primary_creg_field = CP_INSTR[scd_pkg::PRI_MSB:scd_pkg::PRI_LSB];
   assign core_reg = CP_INSTR[scd_pkg::CORE_MSB:scd_pkg::CORE_LSB];
   assign cpnum = CP_INSTR[scd_pkg::CPNUM_MSB:scd_pkg::CPNUM_LSB];
   assign opc2 = CP_INSTR[scd_pkg::OPC2_MSB:scd_pkg::OPC2_LSB];
   assign secondary_creg_field = CP_INSTR[scd_pkg::SEC_MSB:scd_pkg::SEC_LSB];

   // every valid, condition-passed instruction naming coprocessor 15 is ours, whatever its class
   assign aimed_here = CP_VALID && CP_COND_PASS && (cpnum == scd_pkg::CPNUM_SYSCTRL);
   assign is_xfer = (CP_INSTR[scd_pkg::CLASS_MSB:scd_pkg::CLASS_LSB] == scd_pkg::CLASS_XFER)
                    && CP_INSTR[scd_pkg::XFER_BIT];
   assign legal = aimed_here && is_xfer && CP_PRIVILEGED;
   assign illegal = aimed_here && !(is_xfer && CP_PRIVILEGED);
   assign ctx.context_relocation_id = pid_r;

   // opcode_1 and crm are not decoded; nonzero values alias the zero form
   always_comb begin
      read_val = scd_pkg::RESET_WORD;
      case (primary_creg_field)
         scd_pkg::REG_ID: begin
            read_val = (opc2 == scd_pkg::OPC2_CACHE_TYPE) ? CACHE_TYPE : ID_WORD;
         end
         scd_pkg::REG_CTRL: begin
            read_val = ctrl_r;
         end
         scd_pkg::REG_TTB: begin
            read_val = ttb_r;
         end
         scd_pkg::REG_DOMAIN: begin
            read_val = domain_r;
         end
         scd_pkg::REG_RELOC: begin
            if (opc2 == scd_pkg::OPC2_CONTEXT) begin
               read_val = context_r;
            end else begin
               read_val = {pid_r, {scd_pkg::PID_LSB{1'b0}}};
            end
         end
         default: begin
            read_val = scd_pkg::RESET_WORD;
         end
      endcase
   end

   // synchronous reset, so sampling the straps inside the reset branch is safe
   always_ff @(posedge MCLK) begin
      if (!RESET_N) begin
         ctrl_r <= scd_pkg::RESET_WORD;
         ctrl_r[scd_pkg::CTRL_HIGH_VECTOR_BIT] <= HIGH_VECTOR_STRAP;
         ctrl_r[scd_pkg::CTRL_BIG_ENDIAN_BIT] <= ENDIAN_STRAP;
         ttb_r <= scd_pkg::RESET_WORD;
         domain_r <= scd_pkg::RESET_WORD;
         pid_r <= scd_pkg::RESET_PID;
         context_r <= scd_pkg::RESET_WORD;
      end else if (legal && !dir_to_core) begin
         // writes to read-only or reserved numbers are dropped
         case (primary_creg_field)
            scd_pkg::REG_CTRL: begin
               ctrl_r <= CP_CORE_DATA;
            end
            scd_pkg::REG_TTB: begin
               ttb_r <= CP_CORE_DATA;
            end
            scd_pkg::REG_DOMAIN: begin
               domain_r <= CP_CORE_DATA;
            end
            scd_pkg::REG_RELOC: begin
               if (opc2 == scd_pkg::OPC2_PID) begin
                  pid_r <= CP_CORE_DATA[scd_pkg::DATA_W-1:scd_pkg::PID_LSB];
               end else if (opc2 == scd_pkg::OPC2_CONTEXT) begin
                  context_r <= CP_CORE_DATA;
               end
            end
            default: begin
               ctrl_r <= ctrl_r;
            end
         endcase
      end
   end

   always_ff @(posedge MCLK) begin
      if (!RESET_N) begin
         done_r <= 1'b0;
         undef_r <= 1'b0;
         core_we_r <= 1'b0;
         core_reg_r <= 4'h0;
         core_rdata_r <= scd_pkg::RESET_WORD;
         cond_r <= 4'h0;
      end else begin
         done_r <= legal;
         undef_r <= illegal;
         core_we_r <= legal && dir_to_core;
         if (aimed_here) begin
            cond_r <= cond;
            core_reg_r <= core_reg;
         end
         if (legal && dir_to_core) begin
            core_rdata_r <= read_val;
         end
      end
   end

   scd_fetch_path u_fetch (
      .mclk(MCLK),
      .reset_n(RESET_N),
      .ctx(ctx.path),
      .fetch_req(FETCH_REQ),
      .fetch_va(FETCH_VA),
      .mva_r(FETCH_MVA),
      .mva_valid_r(FETCH_MVA_VALID),
      .prot_abort(PROT_ABORT),
      .icache_hit(ICACHE_HIT),
      .icache_data(ICACHE_DATA),
      .mmu_pa(MMU_PA),
      .data_valid_r(FETCH_DATA_VALID),
      .data_r(FETCH_DATA),
      .abort_r(FETCH_ABORT),
      .bus_req_r(BUS_REQ),
      .bus_addr_r(BUS_ADDR)
   );

   assign CP_DONE = done_r;
   assign CP_UNDEF = undef_r;
   assign CP_CORE_WE = core_we_r;
   assign CP_CORE_REG = core_reg_r;
   assign CP_CORE_RDATA = core_rdata_r;
   assign CP_COND = cond_r;
   assign CTRL_WORD = ctrl_r;
   assign TTB_WORD = ttb_r;
   assign DOMAIN_WORD = domain_r;
endmodule

//--- src/scd_pkg.sv
// shared constants for the system control coprocessor decode block
package scd_pkg;
   localparam int unsigned DATA_W = 32;
   localparam int unsigned PID_W = 7;
   localparam int unsigned PID_LSB = 25;
   // instruction field positions
   localparam int unsigned COND_MSB = 31;
   localparam int unsigned COND_LSB = 28;
   localparam int unsigned CLASS_MSB = 27;
   localparam int unsigned CLASS_LSB = 24;
   localparam int unsigned OPC1_MSB = 23;
   localparam int unsigned OPC1_LSB = 21;
   localparam int unsigned DIR_BIT = 20;
   localparam int unsigned PRI_MSB = 19;
   localparam int unsigned PRI_LSB = 16;
   localparam int unsigned CORE_MSB = 15;
   localparam int unsigned CORE_LSB = 12;
   localparam int unsigned CPNUM_MSB = 11;
   localparam int unsigned CPNUM_LSB = 8;
   localparam int unsigned OPC2_MSB = 7;
   localparam int unsigned OPC2_LSB = 5;
   localparam int unsigned XFER_BIT = 4;
   localparam int unsigned SEC_MSB = 3;
   localparam int unsigned SEC_LSB = 0;
   // encoding values
   localparam logic [3:0] CLASS_XFER = 4'he;
   localparam logic [3:0] CPNUM_SYSCTRL = 4'hf;
   localparam logic [2:0] OPC2_CACHE_TYPE = 3'h1;
   localparam logic [2:0] OPC2_PID = 3'h0;
   localparam logic [2:0] OPC2_CONTEXT = 3'h1;
   // primary register numbers
   localparam logic [3:0] REG_ID = 4'h0;
   localparam logic [3:0] REG_CTRL = 4'h1;
   localparam logic [3:0] REG_TTB = 4'h2;
   localparam logic [3:0] REG_DOMAIN = 4'h3;
   localparam logic [3:0] REG_RELOC = 4'hd;
   // control register strap-loaded bit positions
   localparam int unsigned CTRL_BIG_ENDIAN_BIT = 7;
   localparam int unsigned CTRL_HIGH_VECTOR_BIT = 13;
   localparam logic [31:0] RESET_WORD = 32'h0000_0000;
   localparam logic [6:0] RESET_PID = 7'h00;
   // identity values: arbitrary neutral values
   localparam logic [31:0] ID_WORD_DEFAULT = 32'h5a00_0010;
   localparam logic [31:0] CACHE_TYPE_DEFAULT = 32'h0000_0000;
endpackage

//--- src/scd_ctx_if.sv
// relocation context passed from the register file to the fetch address path
`timescale 1ns/1ps
interface scd_ctx_if;
   logic [scd_pkg::PID_W-1:0] context_relocation_id;
   modport regs (output context_relocation_id);
   modport path (input context_relocation_id);
endinterface

//--- src/scd_fetch_path.sv
// instruction fetch address path: relocation, cache hit return, miss forwarding
`timescale 1ns/1ps
module scd_fetch_path (
   input wire logic mclk,
   input wire logic reset_n,
   scd_ctx_if.path ctx,
   input wire logic fetch_req,
   input wire logic [31:0] fetch_va,
   output logic [31:0] mva_r,
   output logic mva_valid_r,
   input wire logic prot_abort,
   input wire logic icache_hit,
   input wire logic [31:0] icache_data,
   input wire logic [31:0] mmu_pa,
   output logic data_valid_r,
   output logic [31:0] data_r,
   output logic abort_r,
   output logic bus_req_r,
   output logic [31:0] bus_addr_r
);
   logic [31:0] mva_nxt;

   // only the lowest 32 MB window is relocated, so mapped kernel space is unaffected
   always_comb begin
      mva_nxt = fetch_va;
      if (fetch_va[31:scd_pkg::PID_LSB] == '0) begin
         mva_nxt = {ctx.context_relocation_id, fetch_va[scd_pkg::PID_LSB-1:0]};
      end
   end

   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         mva_r <= scd_pkg::RESET_WORD;
         mva_valid_r <= 1'b0;
      end else begin
         mva_valid_r <= fetch_req;
         if (fetch_req) begin
            mva_r <= mva_nxt;
         end
      end
   end

   // cache and mmu answer in the same cycle the modified address is presented; results register one cycle later
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         data_valid_r <= 1'b0;
         data_r <= scd_pkg::RESET_WORD;
         abort_r <= 1'b0;
         bus_req_r <= 1'b0;
         bus_addr_r <= scd_pkg::RESET_WORD;
      end else begin
         data_valid_r <= mva_valid_r && !prot_abort && icache_hit;
         abort_r <= mva_valid_r && prot_abort;
         bus_req_r <= mva_valid_r && !prot_abort && !icache_hit;
         if (mva_valid_r && !prot_abort && icache_hit) begin
            data_r <= icache_data;
         end
         if (mva_valid_r && !prot_abort && !icache_hit) begin
            bus_addr_r <= mmu_pa;
         end
      end
   end
endmodule

//--- verification/scd_top_monitor.sv
// port assertions for the coprocessor decode top
`timescale 1ns/1ps
module scd_top_monitor (
   input wire logic MCLK,
   input wire logic RESET_N,
   input wire logic HIGH_VECTOR_STRAP,
   input wire logic ENDIAN_STRAP,
   input wire logic CP_VALID,
   input wire logic [31:0] CP_INSTR,
   input wire logic CP_COND_PASS,
   input wire logic CP_PRIVILEGED,
   input wire logic [31:0] CP_CORE_DATA,
   input wire logic CP_DONE,
   input wire logic CP_UNDEF,
   input wire logic CP_CORE_WE,
   input wire logic [3:0] CP_CORE_REG,
   input wire logic [3:0] CP_COND,
   input wire logic [31:0] CTRL_WORD,
   input wire logic FETCH_REQ,
   input wire logic [31:0] FETCH_VA,
   input wire logic [31:0] FETCH_MVA,
   input wire logic FETCH_MVA_VALID,
   input wire logic PROT_ABORT,
   input wire logic ICACHE_HIT,
   input wire logic [31:0] ICACHE_DATA,
   input wire logic [31:0] MMU_PA,
   input wire logic FETCH_DATA_VALID,
   input wire logic [31:0] FETCH_DATA,
   input wire logic FETCH_ABORT,
   input wire logic BUS_REQ,
   input wire logic [31:0] BUS_ADDR
);
   default clocking @(posedge MCLK); endclocking
   default disable iff (!RESET_N);
   sequence s_taken; CP_VALID && CP_COND_PASS && CP_INSTR[11:8] == 4'hf; endsequence
   sequence s_legal; s_taken ##0 (CP_PRIVILEGED && CP_INSTR[27:24] == 4'he && CP_INSTR[4]); endsequence
   chk_legal_done: assert property (s_legal |=> CP_DONE && !CP_UNDEF)
      else $error("legal transfer not completed");
   chk_unpriv_trap: assert property (s_taken ##0 !CP_PRIVILEGED |=> CP_UNDEF && !CP_DONE)
      else $error("unprivileged transfer not trapped");
   chk_form_trap: assert property (s_taken ##0 (CP_INSTR[27:24] != 4'he || !CP_INSTR[4]) |=> CP_UNDEF)
      else $error("bad form not trapped");
   chk_quiet_other: assert property (!(CP_VALID && CP_COND_PASS && CP_INSTR[11:8] == 4'hf) |=>
      !CP_DONE && !CP_UNDEF)
      else $error("answer without a taken transfer");
   chk_field_report: assert property (s_taken |=>
      CP_CORE_REG == $past(CP_INSTR[15:12]) && CP_COND == $past(CP_INSTR[31:28]))
      else $error("fields not reported");
   chk_dir_select: assert property (s_legal |=> CP_CORE_WE == $past(CP_INSTR[20]))
      else $error("direction not honoured");
   chk_ctrl_write: assert property (s_legal ##0 (!CP_INSTR[20] && CP_INSTR[19:16] == 4'h1) |=>
      CTRL_WORD == $past(CP_CORE_DATA))
      else $error("control write lost");
   chk_reset_straps: assert property ($rose(RESET_N) |->
      CTRL_WORD == {18'h0, $past(HIGH_VECTOR_STRAP), 5'h0, $past(ENDIAN_STRAP), 7'h0})
      else $error("control reset value wrong");
   chk_mva_pass: assert property (FETCH_REQ && FETCH_VA[31:25] != 7'h0 |=>
      FETCH_MVA_VALID && FETCH_MVA == $past(FETCH_VA))
      else $error("modified address wrong");
   chk_hit_return: assert property (FETCH_MVA_VALID && !PROT_ABORT && ICACHE_HIT |=>
      FETCH_DATA_VALID && !BUS_REQ && FETCH_DATA == $past(ICACHE_DATA))
      else $error("hit data not returned");
   chk_miss_external: assert property (FETCH_MVA_VALID && !PROT_ABORT && !ICACHE_HIT |=>
      BUS_REQ && !FETCH_DATA_VALID && BUS_ADDR == $past(MMU_PA))
      else $error("miss not sent out");
endmodule
bind scd_top scd_top_monitor mon (.*);

//--- verification/scd_core_model.sv
// integer core stand-in issuing coprocessor transfers
`timescale 1ns/1ps
module scd_core_model (
   input wire logic mclk,
   output logic cp_valid,
   output logic [31:0] cp_instr,
   output logic cp_cond_pass,
   output logic cp_privileged,
   output logic [31:0] cp_core_data
);
   initial begin
      cp_valid = 1'b0;
      cp_instr = 32'h0;
      cp_cond_pass = 1'b0;
      cp_privileged = 1'b0;
      cp_core_data = 32'h0;
   end
   // callers keep opcode_1 and the secondary fields zero, so aliasing stays unseen
   task automatic issue(input logic [31:0] i, input logic p, input logic c, input logic [31:0] d);
      cp_valid = 1'b1;
      cp_instr = i;
      cp_privileged = p;
      cp_cond_pass = c;
      cp_core_data = d;
      @(posedge mclk);
      #1;
   endtask
   // released lines show the inverse, not a stale copy
   task automatic idle();
      cp_valid = 1'b0;
      cp_instr = ~cp_instr;
      cp_core_data = ~cp_core_data;
   endtask
endmodule

//--- verification/sysctrl_coproc_access_decode_tb_top.sv
// self-checking bench for the coprocessor decode block
`timescale 1ns/1ps
module sysctrl_coproc_access_decode_tb_top;
   typedef struct {logic [31:0] i; logic p; logic [31:0] d; logic dn; logic un; logic we; logic [31:0] rd;} scd_row_t;
   logic mclk = 1'b0;
   logic reset_n = 1'b0;
   logic hv = 1'b1;
   logic es = 1'b1;
   logic freq = 1'b0;
   logic [31:0] fva = 32'h0;
   logic pab = 1'b0;
   logic hit = 1'b0;
   logic [31:0] idat = 32'h0;
   logic [31:0] pa = 32'h0;
   logic cv, cc, cpv, done, undef, we, mvv, fdv, fab, breq;
   logic [31:0] ci, cd, rdat, ctrl, ttb, dom, modified_virtual_address, fdat, badr;
   logic [3:0] creg, cond;
   int failures = 0;
   int n_tests = 0;
   always #2.5 mclk = ~mclk;
   function automatic logic [31:0] mk(input logic l, input logic [3:0] n, input logic [3:0] r, input logic [2:0] o);
      return {4'he, 4'he, 3'h0, l, n, r, 4'hf, o, 1'b1, 4'h0};
   endfunction
   scd_row_t rows [16] = '{
      '{mk(0, 1, 0, 0), 1, 32'h0000_1085, 1, 0, 0, 0}, '{mk(1, 1, 3, 0), 1, 0, 1, 0, 1, 32'h0000_1085},
      '{mk(0, 2, 0, 0), 1, 32'habcd_0000, 1, 0, 0, 0}, '{mk(1, 2, 4, 0), 1, 0, 1, 0, 1, 32'habcd_0000},
      '{mk(0, 3, 0, 0), 1, 32'h5555_5555, 1, 0, 0, 0}, '{mk(1, 3, 5, 0), 1, 0, 1, 0, 1, 32'h5555_5555},
      '{mk(1, 0, 6, 0), 1, 0, 1, 0, 1, scd_pkg::ID_WORD_DEFAULT},
      '{mk(1, 0, 7, 1), 1, 0, 1, 0, 1, scd_pkg::CACHE_TYPE_DEFAULT},
      '{mk(0, 1, 0, 0), 0, 0, 0, 1, 0, 0}, '{mk(1, 1, 8, 0), 0, 0, 0, 1, 0, 0},
      '{mk(1, 1, 9, 0), 1, 0, 1, 0, 1, 32'h0000_1085},
      '{mk(1, 1, 9, 0) & ~32'h10, 1, 0, 0, 1, 0, 0}, '{mk(1, 1, 9, 0) ^ 32'h0200_0000, 1, 0, 0, 1, 0, 0},
      '{mk(0, 13, 0, 1), 1, 32'h1357_9bdf, 1, 0, 0, 0}, '{mk(1, 13, 11, 1), 1, 0, 1, 0, 1, 32'h1357_9bdf},
      '{mk(1, 4, 1, 0), 1, 0, 1, 0, 1, 32'h0000_0000}};
   scd_core_model core (.mclk(mclk), .cp_valid(cv), .cp_instr(ci), .cp_cond_pass(cc), .cp_privileged(cpv),
      .cp_core_data(cd));
   scd_top DUT (.MCLK(mclk), .RESET_N(reset_n), .HIGH_VECTOR_STRAP(hv), .ENDIAN_STRAP(es), .CP_VALID(cv),
      .CP_INSTR(ci), .CP_COND_PASS(cc), .CP_PRIVILEGED(cpv), .CP_CORE_DATA(cd), .CP_DONE(done), .CP_UNDEF(undef),
      .CP_CORE_WE(we), .CP_CORE_REG(creg), .CP_CORE_RDATA(rdat), .CP_COND(cond), .CTRL_WORD(ctrl), .TTB_WORD(ttb),
      .DOMAIN_WORD(dom), .FETCH_REQ(freq), .FETCH_VA(fva), .FETCH_MVA(modified_virtual_address), .FETCH_MVA_VALID(mvv), .PROT_ABORT(pab),
      .ICACHE_HIT(hit), .ICACHE_DATA(idat), .MMU_PA(pa), .FETCH_DATA_VALID(fdv), .FETCH_DATA(fdat),
      .FETCH_ABORT(fab), .BUS_REQ(breq), .BUS_ADDR(badr));
   task automatic chk(input bit ok, input string m);
      n_tests++;
      if (!ok) begin
         failures++;
         $display("BAD t=%0t %s", $time, m);
      end
   endtask
   task automatic step();
      @(posedge mclk);
      #1;
   endtask
   task automatic fetch(input logic [31:0] va, input logic a, input logic h, input logic [31:0] mv, input logic [2:0] k);
      freq = 1'b1;
      fva = va;
      step();
      freq = 1'b0;
      fva = ~va;
      chk(mvv === 1'b1 && modified_virtual_address === mv, "modified address");
      pab = a;
      hit = h;
      idat = va ^ 32'h3c3c_3c3c;
      pa = va ^ 32'h8000_0000;
      step();
      chk({fdv, fab, breq} === k, "fetch outcome");
      if (k[0]) chk(badr === (va ^ 32'h8000_0000), "bus address");
      else chk(k[2] ? fdat === (va ^ 32'h3c3c_3c3c) : fab === 1'b1, "fetch data");
      pab = ~a;
      hit = ~h;
      idat = ~idat;
      pa = ~pa;
   endtask
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   initial begin
      repeat (8) step();
      reset_n = 1'b1;
      step();
      chk(ctrl === 32'h0000_2080 && done === 1'b0, "strap reset value");
      $display("end reset");
      foreach (rows[k]) begin
         core.issue(rows[k].i, rows[k].p, 1'b1, rows[k].d);
         core.idle();
         chk(done === rows[k].dn && undef === rows[k].un && we === rows[k].we, "answer");
         if (rows[k].we) chk(rdat === rows[k].rd && creg === rows[k].i[15:12], "read data");
         step();
      end
      $display("end table");
      core.issue(mk(1, 1, 9, 0), 1, 0, 0);
      chk(done === 1'b0 && undef === 1'b0, "failed condition answered");
      core.issue(mk(1, 1, 9, 0) ^ 32'h100, 1, 1, 0);
      core.idle();
      chk(done === 1'b0 && undef === 1'b0, "ignored transfer answered");
      core.issue(mk(0, 2, 0, 0), 1, 1, 32'h1234_5678);
      core.issue(mk(1, 2, 10, 0), 1, 1, 0);
      core.idle();
      chk(we === 1'b1 && rdat === 32'h1234_5678, "back to back");
      chk(ttb === 32'h1234_5678 && dom === 32'h5555_5555, "register words");
      core.issue(mk(0, 13, 0, 0), 1, 1, {7'h05, 25'h0});
      core.issue(mk(1, 13, 12, 0), 1, 1, 0);
      core.idle();
      chk(we === 1'b1 && rdat === {7'h05, 25'h0}, "relocation id read back");
      step();
      $display("end transfers");
      fetch(32'h0000_1000, 0, 1, 32'h0a00_1000, 3'b100);
      fetch(32'h4000_0020, 0, 0, 32'h4000_0020, 3'b001);
      fetch(32'h8000_0040, 1, 0, 32'h8000_0040, 3'b010);
      $display("end fetch");
      reset_n = 1'b0;
      hv = 1'b0;
      es = 1'b0;
      repeat (2) step();
      reset_n = 1'b1;
      step();
      chk(ctrl === 32'h0 && done === 1'b0, "second reset");
      $display("end second reset");
      conclude();
   end
endmodule
